//--- dv/acc_regs_props.sv
module acc_regs_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic mod_tick_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic ch1_sample_o,
    input wire logic [7:0] first_channel_phase_delay_o,
    input wire acc_pkg::acc_res_t second_channel_input_resistance_o,
    input wire logic second_channel_gain_polarity_o,
    input wire logic [7:0] second_channel_digital_level_o,
    input wire logic second_channel_mute_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import acc_pkg::*;
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    logic req;
    assign req = cyc_i && stb_i && !ack_o;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_once_a: assert property (req |=> ack_o ##1 !ack_o)
        else $error("ack not a single pulse");
    phase_wr_a: assert property (req && we_i && sel_i[0] && adr_i == 8'h40
        |-> ##2 first_channel_phase_delay_o == $past(dat_i[7:0], 2)) else $error("phase");
    vol_wr_a: assert property (req && we_i && sel_i[0] && adr_i == 8'h43
        |-> ##2 second_channel_digital_level_o == $past(dat_i[7:0], 2)) else $error("vol");
    rst_vals_a: assert property ($fell(rst_i) && $past(rst_i, 2)
        |-> second_channel_digital_level_o == 8'hc9 && first_channel_phase_delay_o == 8'h00)
        else $error("reset values");
    mute_lvl_a: assert property (second_channel_mute_o ==
        (second_channel_digital_level_o == 8'h00)) else $error("mute");
    neg_gain_a: assert property (second_channel_gain_polarity_o
        |-> second_channel_input_resistance_o inside {ACC_RES_10K, ACC_RES_20K})
        else $error("polarity");
    rsvd_bit_a: assert property (ack_o && adr_i == 8'h41
        |-> dat_o[1] == 1'b0 && dat_o[31:8] == 24'h0) else $error("reserved bit");
    tick_hold_a: assert property (!mod_tick_i |=> $stable(ch1_sample_o))
        else $error("delay moved off tick");
    cover property (req && we_i);
    cover property (second_channel_mute_o);
    cover property (second_channel_gain_polarity_o);
endmodule : acc_regs_chk

bind acc_regs acc_regs_chk u_chk (.*);

//--- dv/acc_regs_tb.sv
module acc_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import acc_pkg::*;
    logic clk_i, rst_i, mod_tick_i, ch1_sample_i, cyc_i, stb_i, we_i, ack_o, smp;
    logic kind, coup, pol, mute;
    logic [7:0] adr_i, phase, level, a, d;
    logic [6:0] gain;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o, q;
    acc_src_t src;
    acc_res_t res;
    acc_dyn_t dyn;
    int fails, samples_checked, t0, t;
    acc_regs u_dut (.clk_i(clk_i), .rst_i(rst_i), .mod_tick_i(mod_tick_i),
        .ch1_sample_i(ch1_sample_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .ch1_sample_o(smp), .first_channel_phase_delay_o(phase),
        .second_channel_source_kind_o(kind), .second_channel_input_select_o(src),
        .second_channel_coupling_o(coup), .second_channel_input_resistance_o(res),
        .second_channel_dynamics_o(dyn), .second_channel_analog_gain_o(gain),
        .second_channel_gain_polarity_o(pol), .second_channel_digital_level_o(level),
        .second_channel_mute_o(mute));
    initial begin
        clk_i = 0;
        forever #4 clk_i = ~clk_i;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic report_and_stop;
        $display("fails=%0d samples_checked=%0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] ad, input logic [7:0] dt,
        input logic [3:0] s, output logic [31:0] r);
        int n;
        n = 0;
        cyc_i <= 1;
        stb_i <= 1;
        we_i <= w;
        adr_i <= ad;
        sel_i <= s;
        dat_i <= {24'h0, dt};
        mod_tick_i <= 1'($urandom);
        ch1_sample_i <= 1'($urandom);
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (ack_o !== 1'b1) begin
            fails++;
            $display("[ERR] %0t bus timeout", $time);
            report_and_stop;
        end
        r = dat_o;
        cyc_i <= 0;
        stb_i <= 0;
        @(posedge clk_i);
    endtask : bus
    task automatic meas(input logic [7:0] n, output int c);
        bus(1, 8'h40, n, 4'h1, q);
        mod_tick_i <= 1;
        ch1_sample_i <= 0;
        repeat (270) @(posedge clk_i);
        ch1_sample_i <= 1;
        c = 0;
        do begin
            @(posedge clk_i);
            c++;
        end while (smp !== 1'b1 && c < 300);
        if (smp !== 1'b1) begin
            fails++;
            $display("[ERR] %0t delay line timeout", $time);
            report_and_stop;
        end
        chk(phase, n);
    endtask : meas
    task automatic chk_rst;
        logic [31:0] r;
        for (int i = 0; i < 4; i++) begin
            bus(0, 8'h40 + 8'(i), 8'h00, 4'h1, r);
            chk(r, i == 3 ? 32'hc9 : 32'h0);
        end
        chk(phase, 8'h00);
        chk({mute, level}, 9'h0c9);
    endtask : chk_rst
    // ----------------------------------------
    // Expectations
    // ----------------------------------------
    function automatic logic [7:0] legal_wr(input logic [7:0] ad, input logic [7:0] dt);
        logic [7:0] v;
        v = dt;
        if (ad == 8'h41) begin
            v[1] = 1'b0;
            if (v[6:5] == 2'h3) v[6:5] = 2'h2;
            if (v[3:2] == 2'h3) v[3:2] = 2'h2;
        end
        if (ad == 8'h42) begin
            if (v[7:1] > 7'd84) v[7:1] = v[7:1] - 7'd43;
            v[0] = 1'b0;
        end
        return v;
    endfunction : legal_wr
    function automatic logic [31:0] exp_rd(input logic [7:0] ad, input logic [7:0] dt);
        return {24'h0, ad == 8'h41 ? dt & 8'hfd : dt};
    endfunction : exp_rd
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        fails = 0;
        samples_checked = 0;
        {rst_i, cyc_i, stb_i, we_i, mod_tick_i, ch1_sample_i} = 6'h20;
        {adr_i, sel_i, dat_i} = '0;
        void'($urandom(32'hb866e06b));
        repeat (4) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        chk_rst;
        for (int i = 0; i < 24; i++) begin
            a = 8'h40 + 8'($urandom % 4);
            d = legal_wr(a, 8'($urandom));
            bus(1, a, d, 4'h1, q);
            bus(0, a, 8'h00, 4'h1, q);
            chk(q, exp_rd(a, d));
        end
        for (int s = 0; s < 3; s++) for (int r = 0; r < 3; r++) begin
            bus(1, 8'h42, {7'd84, 1'b0}, 4'h1, q);
            bus(1, 8'h41, {s[0], s[1:0], 1'b1, r[1:0], 2'b01}, 4'h1, q);
            bus(1, 8'h42, {7'd84, 1'(r != 0)}, 4'h1, q);
            chk(kind, s[0]);
            chk(src, s);
            chk(coup, s != 2);
            chk(res, r);
            chk(dyn, 1);
            chk(gain, 84);
            chk(pol, r != 0);
        end
        bus(1, 8'h6c, 8'h08, 4'h1, q);
        chk(dyn, 2);
        bus(1, 8'h42, 8'h00, 4'h1, q);
        bus(1, 8'h41, 8'h00, 4'h1, q);
        chk(dyn, 0);
        bus(1, 8'h43, 8'h00, 4'h1, q);
        chk({mute, level}, 9'h100);
        bus(1, 8'h43, 8'hff, 4'h1, q);
        bus(1, 8'h43, 8'h12, 4'h0, q);
        chk({mute, level}, 9'h0ff);
        bus(1, 8'h50, 8'h5a, 4'h1, q);
        bus(0, 8'h50, 8'h00, 4'h1, q);
        chk(q, 0);
        rst_i <= 1;
        repeat (4) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        chk_rst;
        meas(8'd0, t0);
        meas(8'd5, t);
        chk(t - t0, 5);
        meas(8'd255, t);
        chk(t - t0, 255);
        report_and_stop;
    end
endmodule : acc_regs_tb

//--- rtl/acc_cfg.svh
`ifndef ACC_CFG_SVH
`define ACC_CFG_SVH
// ------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------
`define ACC_IDX_PHASE 8'h40
`define ACC_IDX_INPUT 8'h41
`define ACC_IDX_GAIN 8'h42
`define ACC_IDX_VOLUME 8'h43
`define ACC_IDX_DYNSEL 8'h6c
// ------------------------------------------------
// Reset values
// ------------------------------------------------
`define ACC_RST_PHASE 8'h00
`define ACC_RST_INPUT 8'h00
`define ACC_RST_GAIN 8'h00
`define ACC_RST_VOLUME 8'hc9
`define ACC_RST_DYNSEL 8'h00
// ------------------------------------------------
// Field positions
// ------------------------------------------------
`define ACC_IN_KIND_BIT 7
`define ACC_IN_SEL_HI 6
`define ACC_IN_SEL_LO 5
`define ACC_IN_COUPLE_BIT 4
`define ACC_IN_RES_HI 3
`define ACC_IN_RES_LO 2
`define ACC_IN_RSVD_BIT 1
`define ACC_IN_DYN_BIT 0
`define ACC_GAIN_HI 7
`define ACC_GAIN_LO 1
`define ACC_GAIN_POL_BIT 0
`define ACC_DYNSEL_BIT 3
`define ACC_INPUT_WMASK 8'hfd
`define ACC_FULL_WMASK 8'hff
`define ACC_VOL_MUTE 8'h00
`define ACC_VOL_UNITY 8'hc9
`endif

//--- rtl/acc_pkg.sv
package acc_pkg;
    typedef enum logic [1:0] {
        ACC_SRC_ANA_DIFF = 2'h0,
        ACC_SRC_ANA_SE = 2'h1,
        ACC_SRC_PDM = 2'h2,
        ACC_SRC_RSVD = 2'h3
    } acc_src_t;
    typedef enum logic [1:0] {
        ACC_RES_2K5 = 2'h0,
        ACC_RES_10K = 2'h1,
        ACC_RES_20K = 2'h2,
        ACC_RES_RSVD = 2'h3
    } acc_res_t;
    typedef enum logic [1:0] {
        ACC_DYN_OFF = 2'h0,
        ACC_DYN_ENHANCE = 2'h1,
        ACC_DYN_ALT = 2'h2
    } acc_dyn_t;
    typedef enum {
        ACC_BUS_IDLE,
        ACC_BUS_ACK
    } acc_bus_state_t;
endpackage : acc_pkg

//--- rtl/acc_regs.sv
// Our own choice: the Wishbone interface to the registers.
`include "acc_cfg.svh"
module acc_regs #(
    parameter int DELAY_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic mod_tick_i,
    input wire logic ch1_sample_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic ch1_sample_o,
    output logic [7:0] first_channel_phase_delay_o,
    output logic second_channel_source_kind_o,
    output acc_pkg::acc_src_t second_channel_input_select_o,
    output logic second_channel_coupling_o,
    output acc_pkg::acc_res_t second_channel_input_resistance_o,
    output acc_pkg::acc_dyn_t second_channel_dynamics_o,
    output logic [6:0] second_channel_analog_gain_o,
    output logic second_channel_gain_polarity_o,
    output logic [7:0] second_channel_digital_level_o,
    output logic second_channel_mute_o
);
    import acc_pkg::*;

    // ------------------------------------------------
    // Register state
    // ------------------------------------------------
    logic [7:0] phase;
    logic [7:0] input_setup;
    logic [7:0] gain;
    logic [7:0] volume;
    logic [7:0] dynsel;
    logic wr_phase;
    logic wr_input;
    logic wr_gain;
    logic wr_volume;
    logic wr_dynsel;
    logic [31:0] next_dat;
    logic next_ack;
    acc_bus_state_t state;
    acc_bus_state_t next_state;
    logic wr_hit;

    always_comb begin
        wr_phase = 1'b0;
        wr_input = 1'b0;
        wr_gain = 1'b0;
        wr_volume = 1'b0;
        wr_dynsel = 1'b0;
        next_dat = 32'h0000_0000;
        next_ack = 1'b0;
        next_state = ACC_BUS_IDLE;
        wr_hit = 1'b0;
        case (state)
            ACC_BUS_IDLE: begin
                if (cyc_i && stb_i) begin
                    next_ack = 1'b1;
                    next_state = ACC_BUS_ACK;
                    wr_hit = we_i && sel_i[0];
                    case (adr_i)
                        `ACC_IDX_PHASE: begin
                            next_dat = {24'h00_0000, phase};
                            wr_phase = wr_hit;
                        end
                        `ACC_IDX_INPUT: begin
                            next_dat = {24'h00_0000, input_setup};
                            wr_input = wr_hit;
                        end
                        `ACC_IDX_GAIN: begin
                            next_dat = {24'h00_0000, gain};
                            wr_gain = wr_hit;
                        end
                        `ACC_IDX_VOLUME: begin
                            next_dat = {24'h00_0000, volume};
                            wr_volume = wr_hit;
                        end
                        `ACC_IDX_DYNSEL: begin
                            next_dat = {24'h00_0000, dynsel};
                            wr_dynsel = wr_hit;
                        end
                        default: next_dat = 32'h0000_0000;
                    endcase
                end
            end
            ACC_BUS_ACK: next_state = ACC_BUS_IDLE;
            default: next_state = ACC_BUS_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
            ack_o <= 1'b0;
            state <= ACC_BUS_IDLE;
        end else begin
            dat_o <= next_dat;
            ack_o <= next_ack;
            state <= next_state;
        end
    end

    // ------------------------------------------------
    // Register storage
    // ------------------------------------------------
    acc_cfg_field #(
        .WIDTH(8),
        .RESET_VAL(`ACC_RST_PHASE),
        .WRITE_MASK(`ACC_FULL_WMASK)
    ) u_phase (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(wr_phase),
        .dat_i(dat_i[7:0]),
        .val_o(phase)
    );

    acc_cfg_field #(
        .WIDTH(8),
        .RESET_VAL(`ACC_RST_INPUT),
        .WRITE_MASK(`ACC_INPUT_WMASK)
    ) u_input (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(wr_input),
        .dat_i(dat_i[7:0]),
        .val_o(input_setup)
    );

    acc_cfg_field #(
        .WIDTH(8),
        .RESET_VAL(`ACC_RST_GAIN),
        .WRITE_MASK(`ACC_FULL_WMASK)
    ) u_gain (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(wr_gain),
        .dat_i(dat_i[7:0]),
        .val_o(gain)
    );

    acc_cfg_field #(
        .WIDTH(8),
        .RESET_VAL(`ACC_RST_VOLUME),
        .WRITE_MASK(`ACC_FULL_WMASK)
    ) u_volume (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(wr_volume),
        .dat_i(dat_i[7:0]),
        .val_o(volume)
    );

    acc_cfg_field #(
        .WIDTH(8),
        .RESET_VAL(`ACC_RST_DYNSEL),
        .WRITE_MASK(`ACC_FULL_WMASK)
    ) u_dynsel (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(wr_dynsel),
        .dat_i(dat_i[7:0]),
        .val_o(dynsel)
    );

    // ------------------------------------------------
    // Field decode to datapath
    // ------------------------------------------------
    logic next_kind;
    acc_src_t next_src;
    logic next_couple;
    acc_res_t next_res;
    acc_dyn_t next_dyn;
    logic [6:0] next_gain_code;
    logic next_pol;
    logic next_mute;

    always_comb begin
        next_kind = input_setup[`ACC_IN_KIND_BIT];
        next_src = acc_src_t'(input_setup[`ACC_IN_SEL_HI:`ACC_IN_SEL_LO]);
        // Coupling forced off only for the PDM source
        next_couple = (next_src != ACC_SRC_PDM) && input_setup[`ACC_IN_COUPLE_BIT];
        next_res = acc_res_t'(input_setup[`ACC_IN_RES_HI:`ACC_IN_RES_LO]);
        if (!input_setup[`ACC_IN_DYN_BIT]) begin
            next_dyn = ACC_DYN_OFF;
        end else if (dynsel[`ACC_DYNSEL_BIT]) begin
            next_dyn = ACC_DYN_ALT;
        end else begin
            next_dyn = ACC_DYN_ENHANCE;
        end
        next_gain_code = gain[`ACC_GAIN_HI:`ACC_GAIN_LO];
        // Negative gain honoured only at 10k or 20k
        next_pol = gain[`ACC_GAIN_POL_BIT]
            && (next_res == ACC_RES_10K || next_res == ACC_RES_20K);
        next_mute = (volume == `ACC_VOL_MUTE);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            first_channel_phase_delay_o <= `ACC_RST_PHASE;
            second_channel_source_kind_o <= 1'b0;
            second_channel_input_select_o <= ACC_SRC_ANA_DIFF;
            second_channel_coupling_o <= 1'b0;
            second_channel_input_resistance_o <= ACC_RES_2K5;
            second_channel_dynamics_o <= ACC_DYN_OFF;
            second_channel_analog_gain_o <= 7'h00;
            second_channel_gain_polarity_o <= 1'b0;
            second_channel_digital_level_o <= `ACC_RST_VOLUME;
            second_channel_mute_o <= 1'b0;
        end else begin
            first_channel_phase_delay_o <= phase;
            second_channel_source_kind_o <= next_kind;
            second_channel_input_select_o <= next_src;
            second_channel_coupling_o <= next_couple;
            second_channel_input_resistance_o <= next_res;
            second_channel_dynamics_o <= next_dyn;
            second_channel_analog_gain_o <= next_gain_code;
            second_channel_gain_polarity_o <= next_pol;
            second_channel_digital_level_o <= volume;
            second_channel_mute_o <= next_mute;
        end
    end

    // ------------------------------------------------
    // Channel 1 phase delay line
    // ------------------------------------------------
    logic [(1 << DELAY_W)-2:0] dline;
    logic [(1 << DELAY_W)-2:0] next_dline;
    logic next_ch1;

    always_comb begin
        next_dline = dline;
        if (mod_tick_i) begin
            next_dline = {dline[(1 << DELAY_W)-3:0], ch1_sample_i};
        end
        // Zero means direct pass, else tap n-1 of the line
        if (phase == 8'h00) begin
            next_ch1 = ch1_sample_i;
        end else begin
            next_ch1 = dline[phase - 8'h01];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dline <= '0;
            ch1_sample_o <= 1'b0;
        end else begin
            dline <= next_dline;
            if (mod_tick_i) ch1_sample_o <= next_ch1;
        end
    end
endmodule : acc_regs

// ------------------------------------------------
// One configuration register
// ------------------------------------------------
module acc_cfg_field #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VAL = '0,
    parameter logic [WIDTH-1:0] WRITE_MASK = '1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wr_i,
    input wire logic [WIDTH-1:0] dat_i,
    output logic [WIDTH-1:0] val_o
);
    logic [WIDTH-1:0] next_val;

    always_comb begin
        next_val = val_o;
        if (wr_i) begin
            next_val = dat_i & WRITE_MASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            val_o <= RESET_VAL;
        end else begin
            val_o <= next_val;
        end
    end
endmodule : acc_cfg_field
